// file: mepg_pkg.sv
// package for the eight-channel multi-edge pulse generator
// assumes a single 20 MHz clock and a 32-bit avalon-mm register slave
`default_nettype none
package mepg_pkg;
   localparam int NUM_CH    = 8;
   localparam int NUM_EDGES = 8;
   localparam int CNT_W     = 16;
   localparam int PRE_W     = 8;
   localparam int REP_W     = 8;
   localparam int ADDR_W    = 8;
   // byte offsets, word aligned
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_PERIOD = 8'h04;
   localparam logic [7:0] OFS_PRESC  = 8'h08;
   localparam logic [7:0] OFS_REPEAT = 8'h0C;
   localparam logic [7:0] OFS_INIT   = 8'h10;
   localparam logic [7:0] OFS_OUTEN  = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQMSK = 8'h1C;
   localparam logic [7:0] OFS_EDGE0  = 8'h40;
   // word k of channel c sits at OFS_EDGE0 + 4*(c*4+k): edge 2k low half, 2k+1 high half
   localparam logic [7:0] OFS_EDGE_END = 8'hBC;
   // control register fields
   localparam int CTRL_START  = 0;
   localparam int CTRL_STOP   = 1;
   localparam int CTRL_TRIGEN = 2;
   localparam int CTRL_CONT   = 3;
   localparam int CTRL_PREEN  = 4;
   // status fields
   localparam int ST_DONE = 0;
   localparam int ST_RUN  = 1;
   localparam logic [15:0] RST_PERIOD = 16'hFFFF;
   localparam logic [7:0]  RST_PRESC  = 8'h00;
   localparam logic [7:0]  RST_REPEAT = 8'h01;
   typedef enum logic [1:0] {MEPG_IDLE, MEPG_RUN} mepg_state_t;
endpackage
`default_nettype wire

// file: mepg_cfg_if.sv
// interface carrying configuration from the register file to the channels
// assumes all members are driven from the single ref_clk domain
`default_nettype none
interface mepg_cfg_if;
   logic [15:0] edge_val [8][8];
   logic [7:0]  init_lvl;
   logic [7:0]  out_en;
   logic [15:0] count;
   logic        cyc_start;
   logic        tick;
   logic        running;
   modport regs (output edge_val, output init_lvl, output out_en);
   modport core (output count, output cyc_start, output tick, output running,
                 input edge_val, input init_lvl, input out_en);
   modport chan (input edge_val, input init_lvl, input out_en, input count,
                 input cyc_start, input tick, input running);
endinterface
`default_nettype wire

// file: mepg_channel.sv
// one pulse output channel: toggles on edge matches, reloads initial level
// assumes count/tick/cyc_start come from the shared period counter
`default_nettype none
module mepg_channel #(
   parameter int CH = 0
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   mepg_cfg_if.chan  cfg,
   output var  logic pwm
);
   logic [7:0] hit;
   logic       any_hit;
   // compare the live count with every programmed edge
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_cmp
         assign hit[i] = (cfg.count == cfg.edge_val[CH][i]);
      end
   endgenerate
   // several equal edge values count as one toggle
   assign any_hit = |hit;

   // disabled or idle channel sits at its initial level
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pwm <= 1'b0;
      end else if (!cfg.out_en[CH] || !cfg.running) begin
         pwm <= cfg.init_lvl[CH];                  // [R06] [R07]
      end else if (cfg.cyc_start) begin
         pwm <= cfg.init_lvl[CH];                  // [R10]
      end else if (cfg.tick && any_hit) begin
         pwm <= ~pwm;                              // [R04] [R05]
      end
   end
endmodule
`default_nettype wire

// file: mepg_top.sv
// top of the eight-channel multi-edge pulse generator with avalon-mm slave
// assumes one 20 MHz clock, synchronous active-high reset, trigger synchronous
//
// Contract
// R01: eight pulse outputs share one period counter and one trigger path.
// R02: a 16-bit counter with a programmed terminal value sets the cycle length.
// R03: the counter steps on system clocks, optionally through an 8-bit prescaler.
// R04: each output has eight toggle points, so up to four pulses per cycle.
// R05: an output inverts whenever the counter equals one of its toggle values; a toggle value of 0 loses to the reload unless pre_en is set and presc > 0.
// R06: each output starts every cycle from its own software-chosen level.
// R07: an output produces its waveform only while its enable is set.
// R08: cycles repeat forever or a programmed 1 to 255 times and then stop.
// R09: a sequence starts on a software start or on a trigger input rise.
// R10: at the terminal value the counter returns to zero and levels reload.
// R11: a sticky flag, readable and clearable, marks the end of a finite run.
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`default_nettype none
module mepg_top (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   input  wire logic        trig_in,
   output var  logic [7:0]  pwm_out,
   output var  logic        irq
);
   mepg_cfg_if cfg ();

   // registers
   logic [15:0] edge_reg [8][8];
   logic [15:0] period;
   logic [7:0]  presc;
   logic [7:0]  repeat_cnt;
   logic [7:0]  init_lvl;
   logic [7:0]  out_en;
   logic        trig_en;
   logic        cont_mode;
   logic        pre_en;
   logic        done_st;
   logic        done_msk;
   // core state
   mepg_pkg::mepg_state_t state;
   logic [15:0] count;
   logic [7:0]  pre_cnt;
   logic [7:0]  cyc_left;
   logic        cyc_start;
   logic        trig_d;
   logic        acked;
   logic [7:0]  pwm_w;

   // bus decode
   wire logic        acc       = avs_read | avs_write;
   wire logic        wr_go     = avs_write & acked;   // lands where waitrequest is low
   wire logic        rd_go     = avs_read & ~acked;
   wire logic        sel_ctrl  = (avs_address == mepg_pkg::OFS_CTRL);
   wire logic        sel_per   = (avs_address == mepg_pkg::OFS_PERIOD);
   wire logic        sel_pre   = (avs_address == mepg_pkg::OFS_PRESC);
   wire logic        sel_rep   = (avs_address == mepg_pkg::OFS_REPEAT);
   wire logic        sel_init  = (avs_address == mepg_pkg::OFS_INIT);
   wire logic        sel_oen   = (avs_address == mepg_pkg::OFS_OUTEN);
   wire logic        sel_st    = (avs_address == mepg_pkg::OFS_STATUS);
   wire logic        sel_msk   = (avs_address == mepg_pkg::OFS_IRQMSK);
   // 64 toggle values only fit the 8-bit map as two per word, even slot low
   wire logic        sel_edge  = (avs_address >= mepg_pkg::OFS_EDGE0) &&
                                 (avs_address <= mepg_pkg::OFS_EDGE_END) &&
                                 (avs_address[1:0] == 2'h0);
   wire logic [4:0]  edge_idx  = 5'(avs_address[7:2] - mepg_pkg::OFS_EDGE0[7:2]);
   wire logic [2:0]  edge_ch   = edge_idx[4:2];
   wire logic [2:0]  edge_lo   = {edge_idx[1:0], 1'b0};
   wire logic [2:0]  edge_hi   = {edge_idx[1:0], 1'b1};
   wire logic        be0       = avs_byteenable[0];
   wire logic        be1       = avs_byteenable[1];
   wire logic        be2       = avs_byteenable[2];
   wire logic        be3       = avs_byteenable[3];
   wire logic [15:0] wdat16    = {be1 ? avs_writedata[15:8] : 8'h00,
                                  be0 ? avs_writedata[7:0] : 8'h00};
   wire logic [15:0] wdat_hi   = {be3 ? avs_writedata[31:24] : 8'h00,
                                  be2 ? avs_writedata[23:16] : 8'h00};
   wire logic        sw_start  = wr_go & sel_ctrl & be0 &
                                 avs_writedata[mepg_pkg::CTRL_START];
   wire logic        sw_stop   = wr_go & sel_ctrl & be0 &
                                 avs_writedata[mepg_pkg::CTRL_STOP];
   wire logic        trig_rise = trig_in & ~trig_d;
   wire logic        idle      = (state == mepg_pkg::MEPG_IDLE);
   // start from software always; from the trigger pin only when armed
   wire logic        go        = idle & (sw_start | (trig_en & trig_rise)); // [R09]
   wire logic        running   = (state == mepg_pkg::MEPG_RUN);
   // prescaler: tick every (presc+1) clocks when enabled, else every clock
   wire logic        tick      = running & (!pre_en || pre_cnt == presc);   // [R03]
   wire logic        at_end    = tick & (count == period);                  // [R02]
   wire logic        last_cyc  = !cont_mode && (cyc_left == 8'h01);
   wire logic        fin       = at_end & last_cyc;
   wire logic [7:0]  next_left = fin ? 8'h00 : 8'(cyc_left - 8'h01);

   // register read mux
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (1'b1)
         sel_ctrl: rd_mux = {27'h0, pre_en, cont_mode, trig_en, 2'b00};
         sel_per:  rd_mux = {16'h0, period};
         sel_pre:  rd_mux = {24'h0, presc};
         sel_rep:  rd_mux = {24'h0, repeat_cnt};
         sel_init: rd_mux = {24'h0, init_lvl};
         sel_oen:  rd_mux = {24'h0, out_en};
         sel_st:   rd_mux = {22'h0, cyc_left, running, done_st};
         sel_msk:  rd_mux = {31'h0, done_msk};
         sel_edge: rd_mux = {edge_reg[edge_ch][edge_hi], edge_reg[edge_ch][edge_lo]};
         default:  rd_mux = 32'h0000_0000;  // unmapped reads return zero
      endcase
   end

   // bus handshake: one wait cycle then answer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         acked           <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         acked           <= acc & ~acked;
         avs_waitrequest <= ~(acc & ~acked);
         if (rd_go) avs_readdata <= rd_mux;
      end
   end

   // control registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         period     <= mepg_pkg::RST_PERIOD;
         presc      <= mepg_pkg::RST_PRESC;
         repeat_cnt <= mepg_pkg::RST_REPEAT;
         init_lvl   <= 8'h00;
         out_en     <= 8'h00;
         trig_en    <= 1'b0;
         cont_mode  <= 1'b0;
         pre_en     <= 1'b0;
         done_msk   <= 1'b0;
      end else if (wr_go) begin
         if (sel_ctrl && be0) begin
            trig_en   <= avs_writedata[mepg_pkg::CTRL_TRIGEN];
            cont_mode <= avs_writedata[mepg_pkg::CTRL_CONT];
            pre_en    <= avs_writedata[mepg_pkg::CTRL_PREEN];
         end
         if (sel_per && (be0 || be1)) period <= wdat16;
         if (sel_pre && be0) presc <= avs_writedata[7:0];
         // a count of zero is not meaningful, hold at one
         if (sel_rep && be0) repeat_cnt <= (avs_writedata[7:0] == 8'h00) ? 8'h01
                                            : avs_writedata[7:0];  // [R08]
         if (sel_init && be0) init_lvl <= avs_writedata[7:0];
         if (sel_oen && be0) out_en <= avs_writedata[7:0];
         if (sel_msk && be0) done_msk <= avs_writedata[0];
      end
   end

   // edge table; no reset, software must load it before enabling outputs
   always_ff @(posedge ref_clk) begin
      if (wr_go && sel_edge && (be0 || be1)) begin
         edge_reg[edge_ch][edge_lo] <= wdat16;                   // [R04]
      end
      if (wr_go && sel_edge && (be2 || be3)) begin
         edge_reg[edge_ch][edge_hi] <= wdat_hi;                  // [R04]
      end
   end

   // done flag: completion beats a same-cycle write-one clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         done_st <= 1'b0;
      end else if (fin) begin
         done_st <= 1'b1;                                        // [R11]
      end else if (wr_go && sel_st && be0 && avs_writedata[mepg_pkg::ST_DONE]) begin
         done_st <= 1'b0;                                        // [R11]
      end
   end

   // sequencer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state    <= mepg_pkg::MEPG_IDLE;
         cyc_left <= 8'h00;
      end else begin
         unique case (state)
            mepg_pkg::MEPG_IDLE: if (go) begin
               state    <= mepg_pkg::MEPG_RUN;
               cyc_left <= repeat_cnt;
            end
            mepg_pkg::MEPG_RUN: begin
               if (sw_stop || fin) begin
                  state <= mepg_pkg::MEPG_IDLE;                  // [R08]
               end
               if (at_end && !cont_mode) cyc_left <= next_left;  // [R08]
            end
         endcase
      end
   end

   // shared period counter and prescaler
   always_ff @(posedge ref_clk) begin
      if (rst || go) begin
         count   <= 16'h0000;
         pre_cnt <= 8'h00;
      end else if (running) begin
         pre_cnt <= tick ? 8'h00 : 8'(pre_cnt + 8'h01);          // [R03]
         if (at_end) count <= 16'h0000;                          // [R10]
         else if (tick) count <= 16'(count + 16'h0001);          // [R02]
      end
   end

   // cycle start marker reloads every channel level
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cyc_start <= 1'b0;
         trig_d    <= 1'b0;
         irq       <= 1'b0;
      end else begin
         cyc_start <= go | (at_end & ~last_cyc);                 // [R10]
         trig_d    <= trig_in;
         irq       <= done_st & done_msk;
      end
   end

   assign cfg.edge_val  = edge_reg;
   assign cfg.init_lvl  = init_lvl;
   assign cfg.out_en    = out_en;
   assign cfg.count     = count;
   assign cfg.cyc_start = cyc_start;
   assign cfg.tick      = tick;
   assign cfg.running   = running;

   // eight identical channels on the one shared counter
   genvar c;
   generate
      for (c = 0; c < 8; c++) begin : g_ch
         mepg_channel #(.CH(c)) u_ch (                           // [R01]
            .ref_clk (ref_clk),
            .rst     (rst),
            .cfg     (cfg),
            .pwm     (pwm_w[c])
         );
      end
   endgenerate

   // pins come from the channel flops
   assign pwm_out = pwm_w;
endmodule
`default_nettype wire

// file: mepg_top_assertions.sv
// checker for the pulse generator top: bus handshake, irq, disabled-output levels
// assumes it is bound to mepg_top and sees only its ports
`default_nettype none
module mepg_chk (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [7:0]  pwm_out,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] en_sh;
   logic [7:0] init_sh;
   logic       msk_sh;
   logic [1:0] quiet;
   // decode of taken writes and of the hole below the edge table
   wire take     = avs_write && !avs_waitrequest;
   wire unmapped = avs_address >= 8'h20 && avs_address < mepg_pkg::OFS_EDGE0;
   // shadows; quiet gives the channel flops time to follow a write
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         en_sh   <= 8'h00;
         init_sh <= 8'h00;
         msk_sh  <= 1'b0;
         quiet   <= 2'h0;
      end else begin
         if (take && avs_address == mepg_pkg::OFS_OUTEN) en_sh <= avs_writedata[7:0];
         if (take && avs_address == mepg_pkg::OFS_INIT) init_sh <= avs_writedata[7:0];
         if (take && avs_address == mepg_pkg::OFS_IRQMSK) msk_sh <= avs_writedata[0];
         quiet <= avs_write ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one cycle");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   wait_idle_a: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
      else $error("waitrequest low without a request");
   rd_hold_a: assert property (!$past(avs_read) |-> $stable(avs_readdata))
      else $error("read data changed without a read");
   unmap_zero_a: assert property (avs_read && !avs_waitrequest && unmapped |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   off_level_a: assert property (quiet == 2'h3 |-> ((pwm_out ^ init_sh) & ~en_sh) == 8'h00)
      else $error("disabled output left its initial level");
   irq_mask_a: assert property (!$past(msk_sh) |-> !irq)
      else $error("masked interrupt raised");
   irq_clr_a: assert property ($fell(irq) |-> $past(avs_write, 2))
      else $error("interrupt fell without a write");
   cover property (avs_read && !avs_waitrequest);
   cover property ($rose(irq));
   cover property ($rose(pwm_out[1]));
endmodule
bind mepg_top mepg_chk i_mepg_chk (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_out(pwm_out),
   .irq(irq));
`default_nettype wire

// file: mepg_load.sv
// load model: counts rising edges seen on each pulse output
// assumes outputs are sampled on ref_clk; clr zeroes every count
`default_nettype none
module mepg_load (
   input  wire logic            ref_clk,
   input  wire logic            clr,
   input  wire logic [7:0]      pwm,
   output var  logic [7:0][7:0] rises
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] last;
   // a load only reacts to edges, so levels between runs cost nothing
   always @(posedge ref_clk) begin
      last <= pwm;
      for (int c = 0; c < 8; c++) rises[c] <= clr ? 8'h00 : rises[c] + 8'(pwm[c] & ~last[c]);
   end
endmodule
`default_nettype wire

// file: mepg_tb.sv
// self-checking bench for the pulse generator over avalon-mm
// assumes the load model counts output rises; checker bound separately
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic            ref_clk, rst, avs_read, avs_write, trig_in, clr;
   logic            avs_waitrequest, irq;
   logic [7:0]      avs_address, pwm_out;
   logic [3:0]      avs_byteenable;
   logic [31:0]     avs_writedata, avs_readdata, d;
   logic [7:0][7:0] rises;
   int              errors, checks_done;
   mepg_top i_mepg_top (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .trig_in(trig_in), .pwm_out(pwm_out), .irq(irq));
   mepg_load i_mepg_load (.ref_clk(ref_clk), .clr(clr), .pwm(pwm_out), .rises(rises));
   // pulses per cycle programmed on each channel
   function automatic int kc(input int c);
      return c == 0 ? 2 : (c == 1 ? 4 : 1);
   endfunction
   task automatic finish_test;
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // bus cycles hold the request until waitrequest is sampled low
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
   task automatic go(input logic [31:0] ctrl, input logic [7:0] rep);
      wr(mepg_pkg::OFS_REPEAT, {24'h0, rep});
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      wr(mepg_pkg::OFS_CTRL, ctrl);
   endtask
   // wait for the finite run to end, count pulses, check and clear the flag
   task automatic done_chk(input int n, input logic m);
      do rd(mepg_pkg::OFS_STATUS); while (d[0] !== 1'b1);
      for (int c = 0; c < 8; c++) chk({24'h0, rises[c]}, 32'(kc(c) * n));
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, {31'h0, m});
      wr(mepg_pkg::OFS_STATUS, 32'h1);
      repeat (2) @(posedge ref_clk);
      chk({31'h0, irq}, 32'h0);
      rd(mepg_pkg::OFS_STATUS);
      chk(d & 32'h3, 32'h0);
   endtask
   task automatic t_regs;
      rd(mepg_pkg::OFS_PERIOD);
      chk(d, 32'h0000FFFF);
      rd(mepg_pkg::OFS_PRESC);
      chk(d, 32'h0);
      wr(mepg_pkg::OFS_REPEAT, 32'h0);
      rd(mepg_pkg::OFS_REPEAT);
      chk(d, 32'h1);
      rd(8'h20);
      chk(d, 32'h0);
   endtask
   // toggle value i of channel c; unused slots sit beyond the period
   function automatic logic [15:0] ev(input int c, input int i);
      if (c == 1) return 16'(i + 1);
      if (c == 0 && i < 4) return 16'(i == 0 ? 2 : 2 * i + 1);
      return i < 2 ? 16'(i * 3 + 2) : 16'h0100;
   endfunction
   // every toggle slot is written, two per word, even slot in the low half
   task automatic t_cfg;
      for (int c = 0; c < 8; c++)
         for (int k = 0; k < 4; k++)
            wr(mepg_pkg::OFS_EDGE0 + 8'(4 * (c * 4 + k)), {ev(c, 2 * k + 1), ev(c, 2 * k)});
      rd(mepg_pkg::OFS_EDGE0 + 8'h04);
      chk(d, 32'h0007_0005);
      rd(mepg_pkg::OFS_EDGE_END);
      chk(d, 32'h0100_0100);
      wr(mepg_pkg::OFS_PERIOD, 32'h9);
      wr(mepg_pkg::OFS_INIT, 32'h0F);
      wr(mepg_pkg::OFS_OUTEN, 32'hFF);
   endtask
   task automatic t_trig;
      go(32'h4, 8'h1);
      repeat (20) @(posedge ref_clk);
      rd(mepg_pkg::OFS_STATUS);
      chk(d & 32'h3, 32'h0);
      trig_in <= 1'b1;
      @(posedge ref_clk);
      trig_in <= 1'b0;
      done_chk(1, 1'b1);
   endtask
   task automatic t_pre;
      wr(mepg_pkg::OFS_PRESC, 32'h3);
      go(32'h11, 8'h1);
      repeat (25) @(posedge ref_clk);
      rd(mepg_pkg::OFS_STATUS);
      chk(d & 32'h1, 32'h0);
      done_chk(1, 1'b1);
   endtask
   task automatic t_cont;
      go(32'h9, 8'h1);
      repeat (100) @(posedge ref_clk);
      rd(mepg_pkg::OFS_STATUS);
      chk(d & 32'h3, 32'h2);
      wr(mepg_pkg::OFS_CTRL, 32'h2);
      rd(mepg_pkg::OFS_STATUS);
      chk(d & 32'h2, 32'h0);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // watchdog sized well past the longest expected run
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      finish_test;
   end
   initial begin
      {rst, avs_read, avs_write, trig_in, clr} = 5'b10000;
      {avs_address, avs_writedata, avs_byteenable} = {8'h00, 32'h0, 4'hF};
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs;
      t_cfg;
      go(32'h1, 8'h3);
      done_chk(3, 1'b0);
      wr(mepg_pkg::OFS_IRQMSK, 32'h1);
      go(32'h1, 8'h1);
      done_chk(1, 1'b1);
      wr(mepg_pkg::OFS_OUTEN, 32'h0);
      go(32'h1, 8'h1);
      done_chk(0, 1'b1);
      wr(mepg_pkg::OFS_OUTEN, 32'hFF);
      t_trig;
      t_pre;
      t_cont;
      finish_test;
   end
endmodule
`default_nettype wire
